// ===== verilog/dmaarb_pkg.sv
// dmaarb_pkg: register map, field layout and carrier types for the dma arbiter
package dmaarb_pkg;

    // register byte offsets
    localparam logic [7:0] OFS_OPER = 8'h00; // dma_operation_register
    localparam logic [7:0] OFS_CTRL0 = 8'h04; // channel_control_register 0
    localparam logic [7:0] OFS_CTRL1 = 8'h08; // channel_control_register 1
    localparam logic [7:0] OFS_CNT0 = 8'h0c; // transfer count 0
    localparam logic [7:0] OFS_CNT1 = 8'h10; // transfer count 1
    localparam logic [7:0] OFS_STAT = 8'h14; // engine status, read only

    // request sources
    localparam logic [1:0] SRC_EXT = 2'h0;
    localparam logic [1:0] SRC_MOD = 2'h1;
    localparam logic [1:0] SRC_AUTO = 2'h2;

    // bus modes
    localparam logic [1:0] BUS_STEAL = 2'h0;
    localparam logic [1:0] BUS_BURST = 2'h1;

    // unit sizes and beats per unit
    localparam logic [1:0] SIZE_16 = 2'h3;
    localparam logic [1:0] BEATS_16 = 2'h3;
    localparam logic [1:0] BEATS_1 = 2'h0;

    // bus gap left for other masters after a cycle-steal unit
    localparam logic [1:0] GAP_ONE = 2'h1;
    localparam logic [1:0] GAP_TWO = 2'h2;

    localparam logic [15:0] CNT_LAST = 16'h0001;
    localparam logic [31:0] RESET_WORD = 32'h0000_0000;

    // dma_operation_register layout
    typedef struct packed {
        logic priority_select_bit; // bit 3: 0 fixed, 1 round-robin
        logic address_error_flag; // bit 2
        logic nmi_abort_flag; // bit 1
        logic master_enable_bit; // bit 0
    } dmaarb_oper_t;

    // channel_control_register layout
    typedef struct packed {
        logic [1:0] req_source; // bits 9:8
        logic [1:0] unit_size; // bits 7:6: 1/2/4/16 bytes
        logic [1:0] bus_mode_bits; // bits 5:4
        logic ack_placement_bit; // bit 3: 0 read cycle, 1 write cycle
        logic address_mode_bit; // bit 2: 0 dual, 1 single
        logic transfer_end_flag; // bit 1
        logic channel_enable_bit; // bit 0
    } dmaarb_ctrl_t;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_BUSREQ,
        ST_READ,
        ST_WRITE,
        ST_SINGLE,
        ST_UNIT_END
    } dmaarb_state_t;

    // bus cycle request toward the bus state controller
    typedef struct packed {
        logic valid;
        logic write;
        logic single;
        logic chan;
        logic [31:0] wdata;
    } dmaarb_cyc_t;

endpackage : dmaarb_pkg

// ===== verilog/dmaarb_prio.sv
// dmaarb_prio: channel selection with fixed and round-robin priority
`timescale 1ns/1ps
module dmaarb_prio
    import dmaarb_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [1:0] req,
    input wire logic prio_rr,
    input wire logic ch0_steal,
    input wire logic accept,
    input wire logic accept_ch,
    input wire logic done,
    input wire logic done_ch,
    output logic grant_valid,
    output logic grant_ch
);

    typedef struct packed {
        logic rr_low; // channel that currently holds low priority
        logic alt_ch1; // fixed steal: prefer channel 1 next
    } dmaarb_prio_st_t;

    dmaarb_prio_st_t s_q;
    dmaarb_prio_st_t s_d;

    ////////////////////////////////////////////////////////////////////////
    // selection and priority state update
    always_comb
    begin
        s_d = s_q;
        grant_valid = |req;
        if (req == 2'b01)
        begin
            grant_ch = 1'b0;
        end
        else if (req == 2'b10)
        begin
            grant_ch = 1'b1;
        end
        else if (prio_rr)
        begin
            grant_ch = ~s_q.rr_low;
        end
        else
        begin
            grant_ch = s_q.alt_ch1;
        end
        // channel that just finished takes low priority
        if (done && prio_rr)
        begin
            s_d.rr_low = done_ch;
        end
        // after a channel 0 steal, channel 1 gets the next slot
        if (accept && !prio_rr)
        begin
            s_d.alt_ch1 = !accept_ch && ch0_steal;
        end
        // nothing pending: in fixed mode the next start serves channel 0 first
        if (!grant_valid)
        begin
            s_d.alt_ch1 = 1'b0;
        end
    end

    // channel 1 ranks first out of reset in round-robin, channel 0 in fixed mode
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            s_q <= '0;
        end
        else
        begin
            s_q <= s_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // checks
    a_fixed_ch0_first: assert property (@(posedge pclk) disable iff (!presetn)
        (req == 2'b11 && !prio_rr && !s_q.alt_ch1) |-> (grant_ch == 1'b0))
        else $error("fixed mode did not favour channel 0");
    a_only_one_req: assert property (@(posedge pclk) disable iff (!presetn)
        (req == 2'b10) |-> (grant_valid && grant_ch))
        else $error("lone channel 1 request not granted");
    a_rr_low_moves: assert property (@(posedge pclk) disable iff (!presetn)
        (done && prio_rr && req == 2'b11) |=> (grant_ch == !$past(done_ch)))
        else $error("round-robin did not pass priority on");
    a_steal_alt_next: assert property (@(posedge pclk) disable iff (!presetn)
        (accept && !accept_ch && !prio_rr && ch0_steal) ##1 (req == 2'b11 && !accept)
        |-> grant_ch)
        else $error("channel 1 not accepted after channel 0 steal");
    c_rr_switch: cover property (@(posedge pclk) disable iff (!presetn)
        done && prio_rr && s_q.rr_low != done_ch);

endmodule : dmaarb_prio

// ===== verilog/dmaarb_top.sv
// dmaarb_top: two-channel dma arbitration and transfer-type sequencing
//
// Chosen here: the placing of the registers and the APB interface to the registers.
`timescale 1ns/1ps
module dmaarb_top
    import dmaarb_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [1:0] ext_req_pin,
    input wire logic [1:0] module_req,
    input wire logic nmi_event,
    input wire logic addr_error_event,
    output logic bus_req,
    input wire logic bus_gnt,
    output dmaarb_cyc_t cyc,
    input wire logic cyc_done,
    input wire logic [31:0] cyc_rdata,
    output logic [1:0] transfer_acknowledge
);

    typedef struct packed {
        dmaarb_state_t st;
        logic chan;
        logic [1:0] beat;
        logic [1:0] gap;
        logic [31:0] hold;
        logic [1:0] ack;
        dmaarb_oper_t oper;
        dmaarb_ctrl_t [1:0] ctrl;
        logic [1:0][15:0] cnt;
        logic [1:0] sync1;
        logic [1:0] sync2;
        logic [1:0] sync3;
        logic [1:0] external_transfer_request_lvl;
        logic [31:0] rdata;
        logic err;
    } dmaarb_state_all_t;

    dmaarb_state_all_t s_q;
    dmaarb_state_all_t s_d;

    logic [1:0] req;
    logic grant_valid;
    logic grant_ch;
    logic accept;
    logic unit_done;
    logic keep_going;
    dmaarb_ctrl_t cur;

    ////////////////////////////////////////////////////////////////////////
    // helpers

    // channel may start a transfer
    function automatic logic chan_ok(input dmaarb_oper_t o, input dmaarb_ctrl_t c);
        chan_ok = c.channel_enable_bit && o.master_enable_bit && !c.transfer_end_flag
            && !o.nmi_abort_flag && !o.address_error_flag;
    endfunction : chan_ok

    // pending request from the selected source
    function automatic logic chan_req(input dmaarb_oper_t o, input dmaarb_ctrl_t c,
        input logic ext, input logic modr);
        logic src;
        src = 1'b0;
        if (c.req_source == SRC_EXT)
            src = ext;
        else if (c.req_source == SRC_MOD)
            src = modr;
        else if (c.req_source == SRC_AUTO)
            src = 1'b1;
        // single address runs only from the external request
        if (c.address_mode_bit && c.req_source != SRC_EXT)
            src = 1'b0;
        chan_req = chan_ok(o, c) && src;
    endfunction : chan_req

    // acknowledge for one cycle kind
    function automatic logic ack_for(input dmaarb_state_t st, input dmaarb_ctrl_t c);
        ack_for = (st == ST_SINGLE)
            || (st == ST_READ && !c.ack_placement_bit)
            || (st == ST_WRITE && c.ack_placement_bit);
    endfunction : ack_for

    ////////////////////////////////////////////////////////////////////////
    // request gathering and arbitration
    assign req[0] = chan_req(s_q.oper, s_q.ctrl[0], s_q.external_transfer_request_lvl[0], module_req[0]);
    assign req[1] = chan_req(s_q.oper, s_q.ctrl[1], s_q.external_transfer_request_lvl[1], module_req[1]);
    assign accept = (s_q.st == ST_IDLE) && (s_q.gap == 2'h0) && grant_valid;
    assign unit_done = (s_q.st == ST_UNIT_END);
    assign cur = s_q.ctrl[s_q.chan];
    assign keep_going = req[s_q.chan] && (s_q.cnt[s_q.chan] != CNT_LAST);

    dmaarb_prio u_prio (
        .pclk(pclk),
        .presetn(presetn),
        .req(req),
        .prio_rr(s_q.oper.priority_select_bit),
        .ch0_steal(s_q.ctrl[0].bus_mode_bits == BUS_STEAL),
        .accept(accept),
        .accept_ch(grant_ch),
        .done(unit_done),
        .done_ch(s_q.chan),
        .grant_valid(grant_valid),
        .grant_ch(grant_ch)
    );

    ////////////////////////////////////////////////////////////////////////
    // next state: pins, sequencer, registers
    always_comb
    begin
        s_d = s_q;
        // request pins: three stages, level moves once two agree
        s_d.sync1 = ext_req_pin;
        s_d.sync2 = s_q.sync1;
        s_d.sync3 = s_q.sync2;
        for (int i = 0; i < 2; i++)
        begin
            if (s_q.sync2[i] == s_q.sync3[i])
                s_d.external_transfer_request_lvl[i] = s_q.sync3[i];
        end

        // sequencer
        case (s_q.st)
            ST_IDLE:
            begin
                if (s_q.gap != 2'h0)
                    s_d.gap = s_q.gap - 2'h1;
                else if (grant_valid)
                begin
                    s_d.chan = grant_ch;
                    s_d.beat = (s_q.ctrl[grant_ch].unit_size == SIZE_16) ? BEATS_16 : BEATS_1;
                    s_d.st = ST_BUSREQ;
                end
            end
            ST_BUSREQ:
            begin
                if (bus_gnt)
                    s_d.st = cur.address_mode_bit ? ST_SINGLE : ST_READ;
            end
            ST_READ:
            begin
                if (cyc_done)
                begin
                    s_d.hold = cyc_rdata;
                    s_d.st = ST_WRITE;
                end
            end
            ST_WRITE:
            begin
                if (cyc_done && s_q.beat != 2'h0)
                begin
                    s_d.beat = s_q.beat - 2'h1;
                    s_d.st = ST_READ;
                end
                else if (cyc_done)
                    s_d.st = ST_UNIT_END;
            end
            ST_SINGLE:
            begin
                if (cyc_done && s_q.beat != 2'h0)
                    s_d.beat = s_q.beat - 2'h1;
                else if (cyc_done)
                    s_d.st = ST_UNIT_END;
            end
            ST_UNIT_END:
            begin
                s_d.cnt[s_q.chan] = s_q.cnt[s_q.chan] - CNT_LAST;
                if (cur.bus_mode_bits == BUS_BURST && keep_going)
                begin
                    // burst keeps the bus
                    s_d.beat = (cur.unit_size == SIZE_16) ? BEATS_16 : BEATS_1;
                    s_d.st = cur.address_mode_bit ? ST_SINGLE : ST_READ;
                end
                else
                begin
                    // steal hands the bus back, longer for single address or when acked late
                    s_d.st = ST_IDLE;
                    s_d.gap = (cur.address_mode_bit || cur.ack_placement_bit)
                        ? GAP_TWO : GAP_ONE;
                    if (cur.bus_mode_bits == BUS_BURST)
                        s_d.gap = 2'h0;
                end
            end
            default:
            begin
                s_d.st = ST_IDLE;
            end
        endcase

        // acknowledge tracks next cycle kind
        s_d.ack = 2'b00;
        s_d.ack[s_d.chan] = ack_for(s_d.st, s_d.ctrl[s_d.chan]);

        // apb: setup phase latches read data and error
        if (psel && !penable)
        begin
            s_d.err = 1'b0;
            s_d.rdata = RESET_WORD;
            if (paddr == OFS_OPER)
                s_d.rdata = {28'h0, s_q.oper};
            else if (paddr == OFS_CTRL0)
                s_d.rdata = {22'h0, s_q.ctrl[0]};
            else if (paddr == OFS_CTRL1)
                s_d.rdata = {22'h0, s_q.ctrl[1]};
            else if (paddr == OFS_CNT0)
                s_d.rdata = {16'h0, s_q.cnt[0]};
            else if (paddr == OFS_CNT1)
                s_d.rdata = {16'h0, s_q.cnt[1]};
            else if (paddr == OFS_STAT)
                s_d.rdata = {27'h0, s_q.chan, 1'b0, s_q.st};
            else
                s_d.err = 1'b1; // unmapped
        end

        // apb write in access phase; flags only cleared by writing 0
        if (psel && penable && pwrite)
        begin
            if (paddr == OFS_OPER)
            begin
                s_d.oper.master_enable_bit = pwdata[0];
                s_d.oper.nmi_abort_flag = s_q.oper.nmi_abort_flag & pwdata[1];
                s_d.oper.address_error_flag = s_q.oper.address_error_flag & pwdata[2];
                s_d.oper.priority_select_bit = pwdata[3];
            end
            else if (paddr == OFS_CTRL0 || paddr == OFS_CTRL1)
            begin
                s_d.ctrl[paddr[3]] = dmaarb_ctrl_t'(pwdata[9:0]);
                s_d.ctrl[paddr[3]].transfer_end_flag =
                    s_q.ctrl[paddr[3]].transfer_end_flag & pwdata[1];
            end
            else if (paddr == OFS_CNT0)
                s_d.cnt[0] = pwdata[15:0];
            else if (paddr == OFS_CNT1)
                s_d.cnt[1] = pwdata[15:0];
        end

        // hardware events win over clearing writes
        s_d.oper.nmi_abort_flag = s_d.oper.nmi_abort_flag | nmi_event;
        s_d.oper.address_error_flag = s_d.oper.address_error_flag | addr_error_event;
        if (s_q.st == ST_UNIT_END && s_q.cnt[s_q.chan] == CNT_LAST)
            s_d.ctrl[s_q.chan].transfer_end_flag = 1'b1;
    end

    // state register
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            s_q <= '0;
        end
        else
        begin
            s_q <= s_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // outputs
    assign prdata = s_q.rdata;
    assign pready = 1'b1;
    assign pslverr = s_q.err && psel && penable;
    assign bus_req = (s_q.st != ST_IDLE);
    assign cyc.valid = (s_q.st == ST_READ) || (s_q.st == ST_WRITE) || (s_q.st == ST_SINGLE);
    assign cyc.write = (s_q.st == ST_WRITE);
    assign cyc.single = (s_q.st == ST_SINGLE);
    assign cyc.chan = s_q.chan;
    assign cyc.wdata = s_q.hold;
    assign transfer_acknowledge = s_q.ack;

    ////////////////////////////////////////////////////////////////////////
    // checks
    a_start_gated: assert property (@(posedge pclk) disable iff (!presetn)
        accept |-> chan_ok(s_q.oper, s_q.ctrl[grant_ch]))
        else $error("channel started while disabled");
    a_read_then_write: assert property (@(posedge pclk) disable iff (!presetn)
        (s_q.st == ST_READ && cyc_done) |=> (cyc.write && cyc.wdata == $past(cyc_rdata)))
        else $error("write did not carry held read data");
    a_transfer_acknowledge_placement: assert property (@(posedge pclk) disable iff (!presetn)
        (cyc.valid && !cyc.single) |-> (transfer_acknowledge[s_q.chan]
        == (cyc.write == cur.ack_placement_bit)))
        else $error("acknowledge in wrong dual cycle");
    a_single_ack: assert property (@(posedge pclk) disable iff (!presetn)
        cyc.single |-> (transfer_acknowledge[s_q.chan] && !cyc.write))
        else $error("single cycle without acknowledge");
    a_steal_release: assert property (@(posedge pclk) disable iff (!presetn)
        (unit_done && cur.bus_mode_bits == BUS_STEAL) |=> (!bus_req [*1] ##1 !bus_req))
        else $error("cycle steal kept the bus");
    a_burst_hold: assert property (@(posedge pclk) disable iff (!presetn)
        (unit_done && cur.bus_mode_bits == BUS_BURST && keep_going) |=> bus_req)
        else $error("burst dropped the bus early");
    a_sixteen_hold: assert property (@(posedge pclk) disable iff (!presetn)
        (s_q.st == ST_WRITE && cyc_done && s_q.beat != 2'h0) |=> (s_q.st == ST_READ && bus_req))
        else $error("16-byte unit released the bus");
    c_single_unit: cover property (@(posedge pclk) disable iff (!presetn)
        cyc.single && cyc_done);
    c_dual_burst: cover property (@(posedge pclk) disable iff (!presetn)
        unit_done && cur.bus_mode_bits == BUS_BURST && keep_going);
    c_both_req: cover property (@(posedge pclk) disable iff (!presetn)
        accept && req == 2'b11);

endmodule : dmaarb_top

// ===== bench/dmaarb_bus_model.sv
// dmaarb_bus_model: bus arbiter and bus controller facing the dma engine
`timescale 1ns/1ps
module dmaarb_bus_model
    import dmaarb_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic bus_req,
    input wire dmaarb_cyc_t cyc,
    input wire logic [1:0] lat,
    output logic bus_gnt,
    output logic cyc_done,
    output logic [31:0] cyc_rdata
);
    logic [1:0] cnt_q;
    // grant a cycle after request; each bus cycle ends after lat waits
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            bus_gnt <= 1'b0;
            cyc_done <= 1'b0;
            cnt_q <= 2'h0;
            cyc_rdata <= 32'h0;
        end
        else
        begin
            bus_gnt <= bus_req;
            cyc_done <= 1'b0;
            cyc_rdata <= ~cyc_rdata; // no stale data off the answer
            if (cyc_done || !cyc.valid || !bus_gnt)
                cnt_q <= lat;
            else if (cnt_q != 2'h0)
                cnt_q <= cnt_q - 2'h1;
            else
            begin
                cyc_done <= 1'b1;
                cyc_rdata <= $urandom;
            end
        end
    end
endmodule : dmaarb_bus_model

// ===== bench/tb_dma_channel_arbiter_transfer_modes.sv
// tb_dma_channel_arbiter_transfer_modes: self-checking bench of the dma arbiter
`timescale 1ns/1ps
module tb_dma_channel_arbiter_transfer_modes;
    import dmaarb_pkg::*;
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic nmi_event = 1'b0, addr_error_event = 1'b0, gap = 1'b1, am, ch;
    logic pready, pslverr, bus_req, bus_gnt, cyc_done, er;
    logic [7:0] paddr = 8'h0;
    logic [31:0] pwdata = 32'h0, prdata, cyc_rdata, rd, last_rd, c;
    logic [31:0] ops[4] = '{32'h1, 32'h3, 32'h5, 32'h0};
    logic [1:0] ext_req_pin = 2'h0, module_req = 2'h0, transfer_acknowledge, lat = 2'h0;
    dmaarb_cyc_t cyc;
    logic [5:0] log_q[$], ex[$];
    int n_fail = 0, checks_done = 0, tmo = 0, n;
    // clock and both sides
    always #2.5 pclk = ~pclk;
    dmaarb_top u_dmaarb_top (.*);
    dmaarb_bus_model u_dmaarb_bus_model (.*);
    ////////////////////////////////////////
    task automatic chk(input logic [31:0] got, exp);
        checks_done++;
        n_fail += int'(got !== exp);
        if (got !== exp)
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    endtask : chk
    task automatic end_sim();
        $display("%0d checks, %0d mismatches", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : end_sim
    // log each finished bus cycle; bound the run
    always @(posedge pclk)
    begin
        tmo <= tmo + 1;
        if (!bus_req)
            gap <= 1'b1;
        if (cyc_done && cyc.valid)
        begin
            log_q.push_back({gap, cyc.single, cyc.write & ~cyc.single, cyc.chan,
                transfer_acknowledge});
            gap <= 1'b0;
            last_rd <= cyc_rdata;
            if (!cyc.single && cyc.write)
                chk(cyc.wdata, last_rd);
        end
        if (tmo == 40000)
            n_fail++;
        if (tmo == 40001)
            end_sim();
    end
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    // log entry: acknowledge to the channel in the chosen cycle
    function automatic logic [5:0] e(input logic g, s, w, ch, am);
        return {g, s, w, ch, (s || w == am) ? {ch, ~ch} : 2'b00};
    endfunction : e
    // n read/write pairs, gap g before each
    task automatic du(input logic g, ch, am, input int n);
        repeat (n)
        begin
            ex.push_back(e(g, 1'b0, 1'b0, ch, am));
            ex.push_back(e(1'b0, 1'b0, 1'b1, ch, am));
        end
    endtask : du
    // n stolen units alternating, first on ch
    task automatic alt(input logic ch, input int n);
        for (int i = 0; i < n; i++)
            du(1'b1, ch ^ i[0], 1'b0, 1);
    endtask : alt
    function automatic logic [31:0] mk(input logic [1:0] src, sz, bm, input logic am, sg);
        return {22'h0, src, sz, bm, am, sg, 2'b01};
    endfunction : mk
    // program, enable, wait for the expected cycles, compare
    task automatic run(input logic [31:0] c0, c1, op, input logic [15:0] n0, n1);
        apb(1'b1, OFS_OPER, op & ~32'h1);
        apb(1'b1, OFS_CNT0, {16'h0, n0});
        apb(1'b1, OFS_CNT1, {16'h0, n1});
        apb(1'b1, OFS_CTRL0, c0);
        apb(1'b1, OFS_CTRL1, c1);
        log_q.delete();
        apb(1'b1, OFS_OPER, op);
        for (int i = 0; i < 800 && log_q.size() < ex.size(); i++)
            @(posedge pclk);
        repeat (30) @(posedge pclk);
        chk(log_q.size(), ex.size());
        foreach (ex[i])
            chk(log_q[i], ex[i]);
        $display("test done: %0d bus cycles", log_q.size());
        ex.delete();
    endtask : run
    // main sequence
    initial
    begin
        void'($urandom(32'h0a99));
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        // reset values, then an unmapped address
        for (int a = 0; a < 28; a += 4)
        begin
            apb(1'b0, 8'(a), 32'h0);
            chk(rd, RESET_WORD);
            chk(er, a == 24);
        end
        module_req <= 2'h3; // on-chip modules keep asking
        // random stolen dual units
        repeat (6)
        begin
            am = 1'($urandom);
            ch = 1'($urandom);
            n = 1 + $urandom % 3;
            lat <= 2'($urandom);
            c = mk($urandom % 2 ? SRC_MOD : SRC_AUTO, 2'h0, BUS_STEAL, am, 1'b0);
            du(1'b1, ch, am, n);
            run(ch ? 32'h0 : c, ch ? c : 32'h0, 32'h1, 16'(n), 16'(n));
            apb(1'b0, ch ? OFS_CTRL1 : OFS_CTRL0, 32'h0);
            chk(rd[1:0], 2'h3);
        end
        // burst, then a 16-byte stolen unit
        du(1'b1, 1'b0, 1'b0, 1);
        du(1'b0, 1'b0, 1'b0, 2);
        run(mk(SRC_AUTO, 2'h2, BUS_BURST, 1'b0, 1'b0), 32'h0, 32'h1, 16'h3, 16'h0);
        du(1'b1, 1'b1, 1'b1, 1);
        du(1'b0, 1'b1, 1'b1, 3);
        run(32'h0, mk(SRC_AUTO, SIZE_16, BUS_STEAL, 1'b1, 1'b0), 32'h1, 16'h0, 16'h1);
        // single address from the external request
        ext_req_pin <= 2'h1;
        ex = '{e(1'b1, 1'b1, 1'b0, 1'b0, 1'b0), e(1'b1, 1'b1, 1'b0, 1'b0, 1'b0)};
        run(mk(SRC_EXT, 2'h0, BUS_STEAL, 1'b0, 1'b1), 32'h0, 32'h1, 16'h2, 16'h0);
        ext_req_pin <= 2'h0;
        // auto-sourced single, aborts and master off stay quiet
        for (int i = 0; i < 4; i++)
        begin
            nmi_event <= (i == 1);
            addr_error_event <= (i == 2);
            @(posedge pclk);
            nmi_event <= 1'b0;
            addr_error_event <= 1'b0;
            c = mk(SRC_AUTO, 2'h0, BUS_STEAL, 1'b0, i == 0);
            run(c, 32'h0, ops[i], 16'h1, 16'h0);
        end
        // fixed priority, both asking
        c = mk(SRC_AUTO, 2'h0, BUS_STEAL, 1'b0, 1'b0);
        alt(1'b0, 4);
        run(c, c, 32'h1, 16'h2, 16'h2);
        // round-robin from reset, a lone request, then both again
        presetn <= 1'b0;
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        alt(1'b1, 4);
        run(c, c, 32'h9, 16'h2, 16'h2);
        alt(1'b0, 1);
        run(c, 32'h0, 32'h9, 16'h1, 16'h0);
        alt(1'b1, 2);
        run(c, c, 32'h9, 16'h1, 16'h1);
        end_sim();
    end
endmodule : tb_dma_channel_arbiter_transfer_modes
